// file: verilog/drs_defs.svh
// command and status constants for the recalibrate / request status responder
// assumes inclusion by both ends and the shared interface
`ifndef DRS_DEFS_SVH
`define DRS_DEFS_SVH
`define DRS_CMD_W 17
`define DRS_FN_RECAL 4'h1
`define DRS_FN_STATUS 4'h2
`define DRS_MOD_STD 4'h0
`define DRS_MOD_VU_FIRST 4'h1
`define DRS_MOD_VU_LAST 4'h7
`define DRS_MOD_DEVICE 4'h9
`define DRS_MOD_TRACK 4'hA
`define DRS_MOD_BAND_RO 4'hB
`define DRS_MOD_BAND_WO 4'hC
`define DRS_MOD_BAND_ER 4'hD
`define DRS_SUB_STD 8'h00
`define DRS_SUB_EXT 8'h01
`define DRS_ATT_MASK 16'h0FFF
`define DRS_EXT_UNSUP_BIT 15
`define DRS_STD_SYNC_BIT 11
`define DRS_STD_POWER_ON_BIT 7
`define DRS_STD_INVALID_BIT 4
`define DRS_DEV_FAIL_MASK 16'hFFF8
`define DRS_DEV_MO_LSB 1
`endif

// file: verilog/drs_pkg.sv
// types shared by both ends of the command/status link
// assumes drs_defs.svh supplies the numeric constants
package drs_pkg;
  typedef enum logic [1:0] {
    DRS_IDLE = 2'b00,
    DRS_EXEC = 2'b01,
    DRS_RESP = 2'b11
  } drs_state_t;
  typedef enum logic [1:0] {
    DRS_MO_OFF = 2'b00,
    DRS_MO_WRITE = 2'b01,
    DRS_MO_TRANS = 2'b11,
    DRS_MO_ERASE = 2'b10
  } drs_mo_t;
endpackage

// file: verilog/drs_link_if.sv
// word-level command/response link between controller and drive
// assumes one shared clock; serial shifting is outside this block
`include "drs_defs.svh"
interface drs_link_if;
  logic [`DRS_CMD_W-1:0] cmd_word;
  logic cmd_valid;
  logic [`DRS_CMD_W-1:0] resp_word;
  logic resp_valid;
  logic attention;
  modport drive (input cmd_word, input cmd_valid, output resp_word, output resp_valid, output attention);
  modport ctrl (output cmd_word, output cmd_valid, input resp_word, input resp_valid, input attention);
endinterface

// file: verilog/drs_drive.sv
// drive end: decodes recalibrate and request status, builds status words
// assumes command words arrive parity-framed on the link, one cycle strobes
`include "drs_defs.svh"

// Summary of operation
// - magnetic recalibrate: cylinder zero, offsets cleared
// - absolute optical: track zero, offset cleared
// - distance optical: no motion, offset cleared
// - status answer: 16 bits plus odd parity
// - standard word bits 15-12 never raise attention
// - modifier 0000 subscript 0: standard status
// - vendor words on modifiers 0001 to 0111
// - modifier 1001: optical device status word
// - modifier 1010: current track position
// - modifiers 1011-1101: band table start/end tracks
// - reserved word or modifier: invalid command fault
// - controller polls bands until first rejection; drs_ctrl does no polling and leaves it to its user
// - controller requests status on protocol timeout
// - attention when spindle loses synchronization
// - power-on flag set at reset and internal reset
// - controller reconfigures after power-on condition
// - extended word: unsupported media flag with attention
// - device bits 15-3 are failures with attention
// - bits 2-1 magneto-optic state, no attention
// - first code digit is bit 2
// - command: function, modifier, subscript, odd parity
// - reserved status fields read zero
module drs_drive #(
  parameter int VU_WORDS = 2,
  parameter int BANDS = 128,
  parameter bit OPTICAL = 1'b1,
  parameter bit SEEK_ABS = 1'b1
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  drs_link_if.drive link,
  input wire logic [3:0] i_std_cond,
  input wire logic i_spindle_sync,
  input wire logic i_fault_reset,
  input wire logic i_media_unsup,
  input wire logic [12:0] i_dev_fail,
  input wire drs_pkg::drs_mo_t i_magneto_optic_write_state,
  input wire logic [15:0] i_track_pos,
  input wire logic [15:0] i_vu_word,
  input wire logic [1:0] i_band_media,
  input wire logic [15:0] i_band_track,
  output logic [15:0] o_track_target,
  output logic o_seek_zero,
  output logic [7:0] o_strobe_offset,
  output logic [7:0] o_track_offset,
  output logic [7:0] o_recovery_offset,
  output logic [2:0] o_vu_sel,
  output logic [7:0] o_band_sel
);
  // parameters the decode cannot serve are refused while elaborating
  if (VU_WORDS < 0 || VU_WORDS > 7) begin
    $error("VU_WORDS out of range");
  end
  if (BANDS < 1 || BANDS > 128) begin
    $error("BANDS out of range");
  end

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  logic [3:0] fn, mdf;
  logic [7:0] sub;
  logic par_ok;
  assign fn = link.cmd_word[16:13];
  assign mdf = link.cmd_word[12:9];
  assign sub = link.cmd_word[8:1];
  assign par_ok = ^link.cmd_word;

  // a modifier/subscript pair the drive can answer
  function automatic logic valid_req(input logic [3:0] m, input logic [7:0] s);
    logic ok;
    ok = 1'b0;
    if (m == `DRS_MOD_STD) ok = (s == `DRS_SUB_STD) || (s == `DRS_SUB_EXT);
    else if (m >= `DRS_MOD_VU_FIRST && m <= `DRS_MOD_VU_LAST)
      ok = (32'(m) <= VU_WORDS);
    else if (m == `DRS_MOD_DEVICE) ok = OPTICAL;
    else if (m == `DRS_MOD_TRACK) ok = OPTICAL && SEEK_ABS;
    else if (m >= `DRS_MOD_BAND_RO && m <= `DRS_MOD_BAND_ER)
      ok = OPTICAL && (32'(s[7:1]) < BANDS) && (i_band_media[1:0] != 2'b00);
    valid_req = ok; // everything else
  endfunction

  // odd parity over a 16-bit word
  function automatic logic odd_par(input logic [15:0] w);
    odd_par = ~(^w);
  endfunction

  // ----------------------------------------------------------------
  // state flags: power-on, sync history, invalid command, sticky attention
  // ----------------------------------------------------------------
  logic power_on_r, invalid_r, sync_seen_r, sync_lost_r;
  logic sync_s1_r, sync_s2_r;
  logic [15:0] std_word, ext_word, dev_word, att_pend_r, ext_seen_r, dev_seen_r, std_seen_r;

  // spindle sync pin crosses in through two flops
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sync_s1_r <= 1'b0;
      sync_s2_r <= 1'b0;
    end else begin
      sync_s1_r <= i_spindle_sync;
      sync_s2_r <= sync_s1_r;
    end
  end

  logic std_read, ext_read, dev_read, is_status, cmd_ok;
  assign is_status = link.cmd_valid && par_ok && fn == `DRS_FN_STATUS;
  assign cmd_ok = valid_req(mdf, sub);
  assign std_read = is_status && cmd_ok && mdf == `DRS_MOD_STD && sub == `DRS_SUB_STD;
  assign ext_read = is_status && cmd_ok && mdf == `DRS_MOD_STD && sub == `DRS_SUB_EXT;
  assign dev_read = is_status && cmd_ok && mdf == `DRS_MOD_DEVICE;

  // sticky flags; a new set wins over the clear by a status read
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      power_on_r <= 1'b1;
      sync_seen_r <= 1'b0;
      sync_lost_r <= 1'b0;
      invalid_r <= 1'b0;
    end else begin
      if (i_fault_reset) power_on_r <= 1'b1;
      else if (std_read) power_on_r <= 1'b0;
      if (sync_s2_r) begin
        sync_seen_r <= 1'b1;
        sync_lost_r <= 1'b0;
      end else if (sync_seen_r) begin
        sync_seen_r <= 1'b0;
        sync_lost_r <= 1'b1;
      end else if (std_read) sync_lost_r <= 1'b0;
      if (link.cmd_valid && (!par_ok || (fn == `DRS_FN_STATUS && !cmd_ok) ||
          (fn != `DRS_FN_STATUS && fn != `DRS_FN_RECAL))) invalid_r <= 1'b1;
      else if (std_read) invalid_r <= 1'b0;
    end
  end

  // standard word: 15-12 conditions, 11 sync, power-on, invalid, sync-loss change
  always_comb begin
    std_word = 16'h0000;
    std_word[15:12] = i_std_cond;
    std_word[`DRS_STD_SYNC_BIT] = sync_s2_r;
    std_word[`DRS_STD_POWER_ON_BIT] = power_on_r;
    std_word[`DRS_STD_INVALID_BIT] = invalid_r;
    std_word[0] = sync_lost_r; // change of status
    ext_word = 16'h0000;
    ext_word[`DRS_EXT_UNSUP_BIT] = OPTICAL && i_media_unsup;
    dev_word = 16'h0000;
    dev_word[15:3] = i_dev_fail;
    dev_word[2:1] = i_magneto_optic_write_state;
  end

  // attention sources: a rising bit latches until its word is read
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      std_seen_r <= 16'h0000;
      ext_seen_r <= 16'h0000;
      dev_seen_r <= 16'h0000;
      att_pend_r <= 16'h0000;
    end else begin
      std_seen_r <= std_word;
      ext_seen_r <= ext_word;
      dev_seen_r <= dev_word;
      att_pend_r[0] <= ((std_word & ~std_seen_r & `DRS_ATT_MASK) != 16'h0000) ||
                       (att_pend_r[0] && !std_read) ||
                       (sync_seen_r && !sync_s2_r);
      att_pend_r[1] <= (ext_word[`DRS_EXT_UNSUP_BIT] && !ext_seen_r[`DRS_EXT_UNSUP_BIT]) ||
                       (att_pend_r[1] && !ext_read);
      att_pend_r[2] <= ((dev_word & ~dev_seen_r & `DRS_DEV_FAIL_MASK) != 16'h0000) ||
                       (att_pend_r[2] && !dev_read);
      att_pend_r[15:3] <= 13'h0000;
    end
  end

  // ----------------------------------------------------------------
  // recalibrate and status answer
  // ----------------------------------------------------------------
  logic [15:0] word;
  always_comb begin
    word = 16'h0000;
    case (mdf)
      `DRS_MOD_STD: word = (sub == `DRS_SUB_EXT) ? ext_word : std_word;
      `DRS_MOD_DEVICE: word = dev_word;
      `DRS_MOD_TRACK: word = i_track_pos;
      `DRS_MOD_BAND_RO, `DRS_MOD_BAND_WO, `DRS_MOD_BAND_ER: word = i_band_track;
      default: word = i_vu_word;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      link.resp_word <= 17'h00000;
      link.resp_valid <= 1'b0;
      link.attention <= 1'b0;
      o_track_target <= 16'h0000;
      o_seek_zero <= 1'b0;
      o_strobe_offset <= 8'h00;
      o_track_offset <= 8'h00;
      o_recovery_offset <= 8'h00;
      o_vu_sel <= 3'h0;
      o_band_sel <= 8'h00;
    end else begin
      link.attention <= (att_pend_r != 16'h0000);
      link.resp_valid <= is_status && cmd_ok;
      o_seek_zero <= 1'b0;
      if (is_status && cmd_ok) link.resp_word <= {word, odd_par(word)};
      if (is_status) begin
        o_vu_sel <= mdf[2:0];
        o_band_sel <= sub;
      end
      if (link.cmd_valid && par_ok && fn == `DRS_FN_RECAL) begin
        if (!OPTICAL) begin
          o_track_target <= 16'h0000;
          o_seek_zero <= 1'b1;
          o_strobe_offset <= 8'h00;
          o_track_offset <= 8'h00;
        end else if (SEEK_ABS) begin
          o_track_target <= 16'h0000;
          o_seek_zero <= 1'b1;
          o_recovery_offset <= 8'h00;
        end else o_recovery_offset <= 8'h00;
      end
    end
  end
endmodule

// file: verilog/drs_ctrl.sv
// controller end: frames command words and captures status answers
// assumes a user that issues one request at a time
`include "drs_defs.svh"
module drs_ctrl (
  input wire logic i_clk,
  input wire logic i_nrst,
  drs_link_if.ctrl link,
  input wire logic i_req,
  input wire logic [3:0] i_fn,
  input wire logic [3:0] i_mod,
  input wire logic [7:0] i_sub,
  input wire logic i_timeout,
  output logic o_cmd_valid,
  output logic [16:0] o_cmd_word,
  output logic o_resp_valid,
  output logic [15:0] o_resp_data,
  output logic o_resp_par_err,
  output logic o_attention,
  output logic o_reconfig_needed
);
  // ----------------------------------------------------------------
  // command framing with odd parity
  // ----------------------------------------------------------------
  logic [15:0] cw;
  assign cw = {i_fn, i_mod, i_sub};
  assign link.cmd_word = o_cmd_word;
  assign link.cmd_valid = o_cmd_valid;

  // a protocol timeout is followed by a standard status request
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_cmd_valid <= 1'b0;
      o_cmd_word <= 17'h00000;
    end else begin
      o_cmd_valid <= i_req || i_timeout;
      // the fixed request word has one bit set, so its parity bit is zero for an odd total
      if (i_timeout) o_cmd_word <= {`DRS_FN_STATUS, `DRS_MOD_STD, `DRS_SUB_STD, 1'b0};
      else if (i_req) o_cmd_word <= {cw, ~(^cw)};
    end
  end

  // answers; parity checked, power-on bit of a standard status answer flags reconfiguration
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_resp_valid <= 1'b0;
      o_resp_data <= 16'h0000;
      o_resp_par_err <= 1'b0;
      o_attention <= 1'b0;
      o_reconfig_needed <= 1'b0;
    end else begin
      o_resp_valid <= link.resp_valid;
      o_attention <= link.attention;
      if (link.resp_valid) begin
        o_resp_data <= link.resp_word[16:1];
        o_resp_par_err <= ~(^link.resp_word);
        if (o_cmd_word[16:1] == {`DRS_FN_STATUS, `DRS_MOD_STD, `DRS_SUB_STD})
          o_reconfig_needed <= link.resp_word[`DRS_STD_POWER_ON_BIT + 1];
      end
    end
  end
endmodule

// file: bench/drs_link_checker.sv
// assertions on the word link between controller end and drive end
// assumes instantiation beside the link interface in the bench top
`include "drs_defs.svh"
module drs_link_checker (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [`DRS_CMD_W-1:0] cmd_word,
  input wire logic cmd_valid,
  input wire logic [`DRS_CMD_W-1:0] resp_word,
  input wire logic resp_valid,
  input wire logic attention
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  // ----------------------------------------
  // command and answer relations
  // ----------------------------------------
  a_resp_odd_parity: assert property (resp_valid |-> ^resp_word)
    else $error("status answer parity is even");
  a_cmd_odd_parity: assert property (cmd_valid |-> ^cmd_word)
    else $error("command word parity is even");
  a_std_gets_answer: assert property (cmd_valid && cmd_word[16:1] == 16'h2000 |=> resp_valid)
    else $error("standard status request got no answer");
  a_recal_no_answer: assert property (cmd_valid && cmd_word[16:13] == 4'h1 |=> !resp_valid)
    else $error("recalibrate produced an answer");
  a_reserved_refused: assert property (cmd_valid && cmd_word[16:13] == 4'h2
    && cmd_word[12:9] inside {4'h8, 4'hE, 4'hF} |=> !resp_valid)
    else $error("reserved modifier was answered");
  a_answer_has_cause: assert property (resp_valid |-> $past(cmd_valid) && $past(cmd_word[16:13]) == 4'h2)
    else $error("answer without a status request");
  // extended word: only the unsupported media flag may be set
  a_ext_reserved_zero: assert property ($past(cmd_valid) && $past(cmd_word[16:1]) == 16'h2001
    && resp_valid |-> resp_word[15:1] == 15'h0)
    else $error("extended word reserved bits not zero");
  a_power_on_attention: assert property ($rose(i_nrst) |-> ##[1:3] attention)
    else $error("attention missing after reset release");
  c_answer: cover property (resp_valid);
  c_recal: cover property (cmd_valid && cmd_word[16:13] == 4'h1);
  c_att_clear: cover property ($fell(attention));
endmodule

// file: bench/drive_recal_status_responder_tb.sv
// bench: controller and drive ends joined by the link, driven on user side
// assumes drive defaults: two vendor words, 128 bands, optical, absolute seek
`include "drs_defs.svh"
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin mismatches++; $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module drive_recal_status_responder_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 0, i_nrst = 0, i_req = 0, i_timeout = 0, i_spindle_sync = 0, i_fault_reset = 0, i_media_unsup = 0;
  logic [3:0] i_fn = 0, i_mod = 0, i_std_cond = 4'hA;
  logic [7:0] i_sub = 0;
  logic [12:0] i_dev_fail = 0;
  logic [1:0] i_band_media = 2'h3;
  drs_pkg::drs_mo_t mo = drs_pkg::DRS_MO_OFF;
  logic [15:0] i_track_pos = 16'hBEEF, i_vu_word = 16'h5A5A, i_band_track = 0, track_target, resp_data;
  logic [7:0] strobe_off, track_off, rec_off, band_sel;
  logic [2:0] vu_sel;
  logic [3:0] rsv [3] = '{4'h8, 4'hE, 4'hF};
  logic seek_zero, seen_seek = 0, resp_valid, par_err, att, reconfig;
  int mismatches = 0, checks_done = 0;
  drs_link_if link ();
  drs_drive u_drs_drive (.i_clk(i_clk), .i_nrst(i_nrst), .link(link.drive), .i_std_cond(i_std_cond),
    .i_spindle_sync(i_spindle_sync), .i_fault_reset(i_fault_reset), .i_media_unsup(i_media_unsup),
    .i_dev_fail(i_dev_fail), .i_magneto_optic_write_state(mo), .i_track_pos(i_track_pos), .i_vu_word(i_vu_word),
    .i_band_media(i_band_media), .i_band_track(i_band_track), .o_track_target(track_target), .o_seek_zero(seek_zero),
    .o_strobe_offset(strobe_off), .o_track_offset(track_off), .o_recovery_offset(rec_off), .o_vu_sel(vu_sel),
    .o_band_sel(band_sel));
  drs_ctrl u_drs_ctrl (.i_clk(i_clk), .i_nrst(i_nrst), .link(link.ctrl), .i_req(i_req), .i_fn(i_fn), .i_mod(i_mod),
    .i_sub(i_sub), .i_timeout(i_timeout), .o_cmd_valid(), .o_cmd_word(), .o_resp_valid(resp_valid),
    .o_resp_data(resp_data), .o_resp_par_err(par_err), .o_attention(att), .o_reconfig_needed(reconfig));
  drs_link_checker u_drs_link_checker (.i_clk(i_clk), .i_nrst(i_nrst), .cmd_word(link.cmd_word),
    .cmd_valid(link.cmd_valid), .resp_word(link.resp_word), .resp_valid(link.resp_valid), .attention(link.attention));
  always #25 i_clk = ~i_clk;
  // the seek pulse lasts one cycle, so it is latched here for later checking
  always @(posedge i_clk) if (seek_zero === 1'b1) seen_seek <= 1'b1;
  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  task automatic wt(input int n);
    repeat (n) @(posedge i_clk);
    #5;
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // bounded wait for an answer; a lost expected answer ends the run early
  task automatic getr(input logic ok, input logic [15:0] mk, input logic [15:0] d);
    int n;
    n = 0;
    while (resp_valid !== 1'b1 && n < 5) begin
      wt(1);
      n++;
    end
    `CHK("answer", ok, resp_valid)
    if (ok) `CHK("data", d & mk, resp_data & mk)
    if (ok) `CHK("parity_err", 1'b0, par_err)
    if (ok && n == 5) results();
  endtask
  task automatic xfer(input logic [3:0] f, m, input logic [7:0] s, input logic ok, input logic [15:0] mk, d);
    i_req = 1'b1;
    {i_fn, i_mod, i_sub} = {f, m, s};
    wt(1);
    i_req = 1'b0;
    getr(ok, mk, d);
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    wt(3);
    i_nrst = 1'b1;
    wt(4);
    `CHK("att", 1'b1, att)
    xfer(4'h2, 4'h0, 8'h00, 1'b1, 16'hFFFF, 16'hA080);
    wt(2);
    `CHK("att", 1'b0, att)
    // condition bits 15-12 change with no read behind them
    i_std_cond = 4'h5;
    wt(3);
    `CHK("att", 1'b0, att)
    $display("test standard done");
    i_media_unsup = 1'b1;
    wt(3);
    `CHK("att", 1'b1, att)
    xfer(4'h2, 4'h0, 8'h01, 1'b1, 16'hFFFF, 16'h8000);
    for (int k = 0; k < 4; k++) begin
      // the state changes well before its word is read, so a wrong mask would show
      mo = drs_pkg::drs_mo_t'(k[1:0]);
      wt(3);
      `CHK("att", 1'b0, att)
      xfer(4'h2, 4'h9, 8'h00, 1'b1, 16'hFFFF, {13'h0, k[1:0], 1'b0});
    end
    i_dev_fail = 13'h1001;
    wt(3);
    `CHK("att", 1'b1, att)
    xfer(4'h2, 4'h9, 8'h00, 1'b1, 16'hFFFF, 16'h800E);
    xfer(4'h2, 4'hA, 8'h00, 1'b1, 16'hFFFF, 16'hBEEF);
    $display("test optical done");
    for (int m = 1; m <= 3; m++) begin
      xfer(4'h2, m[3:0], 8'h00, m <= 2, 16'hFFFF, 16'h5A5A);
      `CHK("vu_sel", m[2:0], vu_sel)
    end
    foreach (rsv[k]) begin
      xfer(4'h2, rsv[k], 8'h00, 1'b0, 16'hFFFF, 16'h0);
    end
    xfer(4'h2, 4'h0, 8'h00, 1'b1, 16'h0010, 16'h0010);
    for (int m = 11; m <= 13; m++) begin
      for (int s = 0; s < 2; s++) begin
        i_band_track = {m[7:0], 7'h0, s[0]};
        xfer(4'h2, m[3:0], s[0] ? 8'hFF : 8'h00, 1'b1, 16'hFFFF, i_band_track);
        `CHK("band_sel", s[0] ? 8'hFF : 8'h00, band_sel)
      end
    end
    // media without bands: the first band poll is refused and flagged invalid
    i_band_media = 2'h0;
    xfer(4'h2, 4'hB, 8'h00, 1'b0, 16'hFFFF, 16'h0);
    i_band_media = 2'h3;
    xfer(4'h2, 4'h0, 8'h00, 1'b1, 16'h0010, 16'h0010);
    $display("test modifiers done");
    xfer(4'h1, 4'h0, 8'h00, 1'b0, 16'hFFFF, 16'h0);
    `CHK("seek_zero", 1'b1, seen_seek)
    `CHK("target", 16'h0, track_target)
    `CHK("offsets", 24'h0, {strobe_off, track_off, rec_off})
    $display("test recal done");
    i_spindle_sync = 1'b1;
    wt(4);
    xfer(4'h2, 4'h0, 8'h00, 1'b1, 16'h0800, 16'h0800);
    wt(2);
    `CHK("att", 1'b0, att)
    i_spindle_sync = 1'b0;
    wt(5);
    `CHK("att", 1'b1, att)
    xfer(4'h2, 4'h0, 8'h00, 1'b1, 16'h0801, 16'h0001);
    $display("test spindle done");
    i_fault_reset = 1'b1;
    wt(1);
    i_fault_reset = 1'b0;
    wt(3);
    `CHK("att", 1'b1, att)
    i_timeout = 1'b1;
    wt(1);
    i_timeout = 1'b0;
    getr(1'b1, 16'h0080, 16'h0080);
    `CHK("reconfig", 1'b1, reconfig)
    $display("test fault done");
    results();
  end
endmodule
